//--- hw/scp_dev.sv
// Summary of operation
// - both words shift most significant bit first
// - eight address bits, then eight data bits
// - data line sampled on serial clock rise
// - serial clock async; values cross safely
// - host keeps serial clock at most 10MHz
// - strobe high for address, low for data
// - read select high reads, low writes
// - device drives line only during read data
// - host sets read select before sampling edge
// - port select active low enables transfers
// - select high: all port inputs ignored
// - select affects no other device interface
// - two address low bits are ignored
// - host programs only with clock, no reset
`timescale 1ns/1ps
`default_nettype none
module scp_dev (
   input wire logic ref_clk,
   input wire logic resetn,
   scp_link_if.dev link,
   input wire logic [scp_pkg::IDX_W-1:0] usr_rd_index,
   output logic [scp_pkg::DATA_W-1:0] usr_rd_data,
   input wire logic usr_st_we,
   input wire logic [scp_pkg::IDX_W-1:0] usr_st_index,
   input wire logic [scp_pkg::DATA_W-1:0] usr_st_data,
   output logic host_wr,
   output logic [scp_pkg::IDX_W-1:0] host_wr_index,
   output logic [scp_pkg::DATA_W-1:0] host_wr_data
);
   import scp_pkg::*;

   // ---------------- link domain (serial clock) ----------------
   logic link_rst_n;
   logic [4:0] bit_cnt;
   logic [ADDR_W-1:0] addr_sh;
   logic [DATA_W-1:0] data_sh;
   logic rd_op;
   logic bad_frame;
   logic [IDX_W-1:0] rd_idx;
   logic rd_tgl;
   logic [IDX_W-1:0] wr_idx;
   logic [DATA_W-1:0] wr_word;
   logic wr_tgl;
   logic [DATA_W-1:0] out_sh;
   logic out_en;

   // ---------------- core domain (ref_clk) ----------------
   logic [DATA_W-1:0] regs [REG_COUNT];
   logic [DATA_W-1:0] rd_word;
   logic rd_meta;
   logic rd_sync;
   logic rd_seen;
   logic wr_meta;
   logic wr_sync;
   logic wr_seen;

   // deselect holds frame logic in reset
   assign link_rst_n = resetn & ~link.port_sel_n;

   always_ff @(posedge link.sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt <= 5'h00;
         addr_sh <= '0;
         data_sh <= '0;
         rd_op <= 1'b0;
         bad_frame <= 1'b0;
      end else begin
         if (bit_cnt != CNT_FRAME_DONE) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
         if (bit_cnt == 5'h00) begin
            rd_op <= link.rd_wr;
         end
         if (bit_cnt < CNT_ADDR_DONE) begin
            if (!link.address_strobe) begin
               bad_frame <= 1'b1;
            end
            addr_sh <= {addr_sh[ADDR_W-2:0], link.serial_data_line};
         end else if (bit_cnt < CNT_FRAME_DONE) begin
            if (link.address_strobe) begin
               bad_frame <= 1'b1;
            end
            data_sh <= {data_sh[DATA_W-2:0], link.serial_data_line};
         end else begin
            // extra clocks after a full frame are not a new frame
            bad_frame <= 1'b1;
         end
      end
   end

   // handoff words survive deselect so the core can still read them
   always_ff @(posedge link.sclk or negedge resetn) begin
      if (!resetn) begin
         rd_idx <= '0;
         rd_tgl <= 1'b0;
         wr_idx <= '0;
         wr_word <= '0;
         wr_tgl <= 1'b0;
      end else if (!link.port_sel_n) begin
         // index taken from six top bits
         if (bit_cnt == CNT_IDX_READY) begin
            rd_idx <= addr_sh[IDX_W-1:0];
            // toggle asks core for read word
            rd_tgl <= ~rd_tgl;
         end
         if (bit_cnt == CNT_LAST_BIT && !rd_op && !bad_frame &&
             !link.address_strobe) begin
            wr_idx <= addr_sh[ADDR_W-1:ADDR_W-IDX_W];
            wr_word <= {data_sh[DATA_W-2:0], link.serial_data_line};
            wr_tgl <= ~wr_tgl;
         end
      end
   end

   // drive on the falling edge so the host sees a settled bit
   always_ff @(negedge link.sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         out_sh <= '0;
         out_en <= 1'b0;
      end else if (bit_cnt == CNT_ADDR_DONE && rd_op && !bad_frame) begin
         // turn line around for read data
         // rd_word settled well before: clock ratio bounds the wait
         out_sh <= rd_word;
         out_en <= 1'b1;
      end else if (bit_cnt == CNT_FRAME_DONE) begin
         out_en <= 1'b0;
      end else if (out_en) begin
         out_sh <= {out_sh[DATA_W-2:0], 1'b0};
      end
   end

   assign link.dev_data_o = out_sh[DATA_W-1];
   assign link.dev_data_oe = out_en;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rd_meta <= 1'b0;
         rd_sync <= 1'b0;
         rd_seen <= 1'b0;
         wr_meta <= 1'b0;
         wr_sync <= 1'b0;
         wr_seen <= 1'b0;
      end else begin
         rd_meta <= rd_tgl;
         rd_sync <= rd_meta;
         rd_seen <= rd_sync;
         wr_meta <= wr_tgl;
         wr_sync <= wr_meta;
         wr_seen <= wr_sync;
      end
   end

   // read word fetched once the index is known stable
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rd_word <= REG_RESET_VAL;
      end else if (rd_sync != rd_seen) begin
         rd_word <= regs[rd_idx];
      end
   end

   // register file; local status write loses to nothing it overlaps
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs[i] <= REG_RESET_VAL;
         end
      end else begin
         if (wr_sync != wr_seen) begin
            regs[wr_idx] <= wr_word;
         end
         // local status update wins a same-cycle clash
         if (usr_st_we) begin
            regs[usr_st_index] <= usr_st_data;
         end
      end
   end

   // announce host writes to the rest of the chip
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         host_wr <= 1'b0;
         host_wr_index <= '0;
         host_wr_data <= '0;
      end else begin
         host_wr <= (wr_sync != wr_seen);
         if (wr_sync != wr_seen) begin
            host_wr_index <= wr_idx;
            host_wr_data <= wr_word;
         end
      end
   end

   // local read port independent of select
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         usr_rd_data <= REG_RESET_VAL;
      end else begin
         usr_rd_data <= regs[usr_rd_index];
      end
   end
endmodule // scp_dev
`default_nettype wire

//--- hw/scp_pkg.sv
`default_nettype none
package scp_pkg;
   // frame layout on the serial data line
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int FRAME_BITS = ADDR_W + DATA_W;
   localparam int IDX_W = 6;
   localparam int REG_COUNT = 64;
   localparam logic [4:0] CNT_IDX_READY = 5'h06;
   localparam logic [4:0] CNT_ADDR_DONE = 5'h08;
   localparam logic [4:0] CNT_LAST_BIT = 5'h0f;
   localparam logic [4:0] CNT_FRAME_DONE = 5'h10;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;

   // link clock timing
   localparam int REF_PERIOD_NS = 20;
   localparam int SCLK_MIN_PERIOD_NS = 100;
   localparam int SCLK_HALF_CYC =
      (SCLK_MIN_PERIOD_NS / 2 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

   typedef enum logic [1:0] {
      SCP_IDLE = 2'b00,
      SCP_START = 2'b01,
      SCP_RUN = 2'b10,
      SCP_END = 2'b11
   } scp_host_state_t;
endpackage
`default_nettype wire

//--- hw/scp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scp_link_if;
   logic sclk;
   logic port_sel_n;
   logic address_strobe;
   logic rd_wr;
   logic host_data_o;
   logic host_data_oe;
   logic dev_data_o;
   logic dev_data_oe;
   logic serial_data_line;

   // weak pull-up when nobody drives
   assign serial_data_line = dev_data_oe ? dev_data_o :
                             (host_data_oe ? host_data_o : 1'b1);

   modport host (
      output sclk, port_sel_n, address_strobe, rd_wr,
      output host_data_o, host_data_oe,
      input serial_data_line
   );
   modport dev (
      input sclk, port_sel_n, address_strobe, rd_wr, serial_data_line,
      output dev_data_o, dev_data_oe
   );
endinterface
`default_nettype wire

//--- hw/scp_host.sv
`timescale 1ns/1ps
`default_nettype none
module scp_host #(
   parameter int HALF_CYC = scp_pkg::SCLK_HALF_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   scp_link_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_rd,
   input wire logic [scp_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [scp_pkg::DATA_W-1:0] cmd_wdata,
   output logic rsp_valid,
   output logic [scp_pkg::DATA_W-1:0] rsp_rdata
);
   import scp_pkg::*;

   scp_host_state_t state;
   logic [7:0] hcnt;
   logic [3:0] bcnt;
   logic [FRAME_BITS-1:0] shreg;
   logic is_rd;
   logic line_meta;
   logic line_sync;
   logic half_done;

   assign half_done = (hcnt == 8'(HALF_CYC - 1));

   // data line comes from the other domain
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         line_meta <= 1'b1;
         line_sync <= 1'b1;
      end else begin
         line_meta <= link.serial_data_line;
         line_sync <= line_meta;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= SCP_IDLE;
         hcnt <= 8'h00;
         bcnt <= 4'h0;
         shreg <= '0;
         is_rd <= 1'b0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
         link.sclk <= 1'b0;
         link.port_sel_n <= 1'b1;
         link.address_strobe <= 1'b0;
         link.rd_wr <= 1'b0;
         link.host_data_o <= 1'b0;
         link.host_data_oe <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         case (state)
            SCP_IDLE: begin
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  shreg <= {cmd_addr, cmd_wdata};
                  is_rd <= cmd_rd;
                  link.port_sel_n <= 1'b0;
                  link.rd_wr <= cmd_rd;
                  link.address_strobe <= 1'b1;
                  link.host_data_o <= cmd_addr[ADDR_W-1];
                  link.host_data_oe <= 1'b1;
                  hcnt <= 8'h00;
                  bcnt <= 4'h0;
                  state <= SCP_START;
               end
            end
            SCP_START: begin
               hcnt <= half_done ? 8'h00 : hcnt + 8'h01;
               if (half_done) begin
                  link.sclk <= 1'b1;
                  state <= SCP_RUN;
               end
            end
            SCP_RUN: begin
               hcnt <= half_done ? 8'h00 : hcnt + 8'h01;
               if (half_done && !link.sclk) begin
                  link.sclk <= 1'b1;
               end else if (half_done) begin
                  link.sclk <= 1'b0;
                  // end of high half: device output has settled
                  if (is_rd && bcnt >= 4'h8) begin
                     rsp_rdata <= {rsp_rdata[DATA_W-2:0], line_sync};
                  end
                  if (bcnt == 4'hf) begin
                     link.host_data_oe <= 1'b0;
                     state <= SCP_END;
                  end else begin
                     bcnt <= bcnt + 4'h1;
                     shreg <= {shreg[FRAME_BITS-2:0], 1'b0};
                     link.host_data_o <= shreg[FRAME_BITS-2];
                     if (bcnt == 4'h7) begin
                        link.address_strobe <= 1'b0;
                        link.host_data_oe <= !is_rd;
                     end
                  end
               end
            end
            SCP_END: begin
               hcnt <= half_done ? 8'h00 : hcnt + 8'h01;
               if (half_done) begin
                  link.port_sel_n <= 1'b1;
                  rsp_valid <= 1'b1;
                  state <= SCP_IDLE;
               end
            end
            default: state <= SCP_IDLE;
         endcase
      end
   end
endmodule // scp_host
`default_nettype wire

//--- dv/scp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module scp_checker (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic sclk,
   input wire logic port_sel_n,
   input wire logic address_strobe,
   input wire logic rd_wr,
   input wire logic host_data_oe,
   input wire logic dev_data_oe
);
   logic sclk_q;
   logic [4:0] rises;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // rises seen in the open frame, cleared while deselected
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sclk_q <= 1'b0;
         rises <= 5'h00;
      end else begin
         sclk_q <= sclk;
         if (port_sel_n) rises <= 5'h00;
         else if (sclk && !sclk_q) rises <= rises + 5'h01;
      end
   end
   sequence open_s;
      $fell(port_sel_n) ##0 address_strobe;
   endsequence
   sequence turn_s;
      $fell(address_strobe) ##0 rd_wr;
   endsequence
   frame_open_a: assert property (open_s |-> ##[2:4] $rose(sclk))
      else $error("first serial clock edge out of place");
   rise_count_a: assert property ($rose(port_sel_n) |-> rises == 5'h10)
      else $error("frame did not carry sixteen clock rises");
   strobe_phase_a: assert property (
      $rose(sclk) && !port_sel_n |-> address_strobe == (rises < 5'h08))
      else $error("strobe level wrong for bit position");
   sclk_high_a: assert property ($rose(sclk) |-> sclk[*3] ##1 !sclk)
      else $error("serial clock high time wrong");
   sel_quiet_a: assert property (port_sel_n |-> !dev_data_oe && !sclk)
      else $error("link active while deselected");
   no_fight_a: assert property (!(dev_data_oe && host_data_oe))
      else $error("both ends drive the data line");
   write_quiet_a: assert property (!rd_wr |-> !dev_data_oe)
      else $error("device drives during a write");
   addr_quiet_a: assert property (address_strobe |-> !dev_data_oe)
      else $error("device drives during address phase");
   rw_steady_a: assert property (
      !port_sel_n && !$past(port_sel_n) |-> $stable(rd_wr))
      else $error("read select moved inside a frame");
   read_turn_a: assert property (
      turn_s |-> !host_data_oe ##[0:4] dev_data_oe)
      else $error("no turnaround for read data");
endmodule // scp_checker
`default_nettype wire

//--- dv/serial_control_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_control_port_tb;
   import scp_pkg::*;
   logic ref_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, cmd_rd = 1'b0;
   logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, rsp_rdata, rd1, rd2;
   logic [7:0] st_data = 8'h00, wr_data, wr_data2, hw_dat;
   logic [5:0] rd_idx = 6'h00, st_idx = 6'h00, wr_idx, wr_idx2, hw_idx;
   logic cmd_ready, rsp_valid, st_we = 1'b0, host_wr, host_wr2;
   logic [15:0] wire_bits, exp_w;
   logic [24:0] rows [9] = '{25'h0045a, 25'h007c3, 25'h105c3, 25'h104c3,
      25'h0fcff, 25'h1ffff, 25'h00081, 25'h10381, 25'h10800};
   int err_count = 0, n_checks = 0, hw_n = 0, hw2_n = 0, r;
   scp_link_if lk();
   scp_link_if lk2();
   always #10 ref_clk = ~ref_clk;
   scp_host scp_host_i (.ref_clk(ref_clk), .resetn(resetn), .link(lk),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rd(cmd_rd),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata));
   scp_dev scp_dev_i (.ref_clk(ref_clk), .resetn(resetn), .link(lk),
      .usr_rd_index(rd_idx), .usr_rd_data(rd1), .usr_st_we(st_we),
      .usr_st_index(st_idx), .usr_st_data(st_data), .host_wr(host_wr),
      .host_wr_index(wr_idx), .host_wr_data(wr_data));
   // second device faces the bench, which breaks the link rules on purpose
   scp_dev scp_dev_i2 (.ref_clk(ref_clk), .resetn(resetn), .link(lk2),
      .usr_rd_index(rd_idx), .usr_rd_data(rd2), .usr_st_we(1'b0),
      .usr_st_index(st_idx), .usr_st_data(st_data), .host_wr(host_wr2),
      .host_wr_index(wr_idx2), .host_wr_data(wr_data2));
   scp_checker scp_checker_i (.ref_clk(ref_clk), .resetn(resetn),
      .sclk(lk.sclk), .port_sel_n(lk.port_sel_n), .rd_wr(lk.rd_wr),
      .address_strobe(lk.address_strobe), .host_data_oe(lk.host_data_oe),
      .dev_data_oe(lk.dev_data_oe));
   always @(posedge lk.sclk)
      if (!lk.port_sel_n) wire_bits <= {wire_bits[14:0], lk.serial_data_line};
   always @(posedge ref_clk) begin
      if (host_wr === 1'b1) begin
         hw_n <= hw_n + 1;
         hw_idx <= wr_idx;
         hw_dat <= wr_data;
      end
      if (host_wr2 === 1'b1) hw2_n <= hw2_n + 1;
   end
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic xfer(logic rd, logic [7:0] a, logic [7:0] d);
      int i;
      chk("ready", 16'h1, {15'h0, cmd_ready});
      {cmd_rd, cmd_addr, cmd_wdata, cmd_valid} = {rd, a, d, 1'b1};
      tick(1);
      cmd_valid = 1'b0;
      for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) tick(1);
      if (i == 400) begin
         chk("timeout", 16'h0, 16'h1);
         end_sim;
      end
      if (rd) chk("rdata", {8'h00, d}, {8'h00, rsp_rdata});
      tick(2);
   endtask
   // bench plays host on the second link with a 32 ns serial clock;
   // writes only, since the read fetch needs a slower clock
   task automatic drive2(logic sel_n, logic [15:0] b, int n, logic bad);
      int k;
      {lk2.port_sel_n, lk2.rd_wr, lk2.host_data_oe} = {sel_n, 2'b01};
      for (k = 0; k < n; k++) begin
         lk2.address_strobe = bad | (k < 8);
         lk2.host_data_o = b[15-k];
         #16 lk2.sclk = 1'b1;
         #16 lk2.sclk = 1'b0;
      end
      #16 {lk2.port_sel_n, lk2.host_data_oe} = 2'b10;
      tick(8);
      rd_idx = b[15:10];
      tick(2);
   endtask
   initial begin
      {lk2.sclk, lk2.port_sel_n, lk2.address_strobe} = 3'b010;
      {lk2.rd_wr, lk2.host_data_o, lk2.host_data_oe} = 3'b000;
      tick(4);
      resetn = 1'b1;
      tick(2);
      for (r = 0; r < 9; r++) begin
         xfer(rows[r][16], rows[r][15:8], rows[r][7:0]);
         chk("wire", rows[r][15:0], wire_bits);
         rd_idx = rows[r][15:10];
         tick(2);
         chk("reg", {8'h00, rows[r][7:0]}, {8'h00, rd1});
         exp_w = {rows[r][15:10], 2'b00, rows[r][7:0]};
         if (!rows[r][16]) begin
            chk("hwr", exp_w, {hw_idx, 2'b00, hw_dat});
         end
         $display("row %0d done", r);
      end
      chk("hw_n", 16'h0004, hw_n[15:0]);
      {st_we, st_idx, st_data} = {1'b1, 6'h02, 8'h3c};
      tick(1);
      st_we = 1'b0;
      xfer(1'b1, 8'h0a, 8'h3c);
      $display("local store done");
      drive2(1'b0, 16'h10a5, 16, 1'b0);
      chk("dev2 ok", 16'h00a5, {8'h00, rd2});
      chk("hw2", 16'h10a5, {wr_idx2, 2'b00, wr_data2});
      drive2(1'b0, 16'h1466, 12, 1'b0);
      chk("abort", {8'h00, REG_RESET_VAL}, {8'h00, rd2});
      drive2(1'b0, 16'h1877, 16, 1'b1);
      chk("bad strobe", {8'h00, REG_RESET_VAL}, {8'h00, rd2});
      drive2(1'b1, 16'h1c55, 16, 1'b0);
      chk("deselected", {8'h00, REG_RESET_VAL}, {8'h00, rd2});
      chk("hw2_n", 16'd1, hw2_n[15:0]);
      $display("link faults done");
      resetn = 1'b0;
      tick(4);
      chk("sel", 16'h1, {15'h0, lk.port_sel_n});
      resetn = 1'b1;
      rd_idx = 6'h01;
      tick(3);
      chk("reset reg", {8'h00, REG_RESET_VAL}, {8'h00, rd1});
      xfer(1'b1, 8'h04, REG_RESET_VAL);
      $display("reset done");
      end_sim;
   end
endmodule // serial_control_port_tb
`default_nettype wire
